//--- smc_debounce.sv
// Detection filter: consecutive equal samples before data counts as valid
`timescale 1ns/10ps
module smc_debounce (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_take,
  input wire logic [smc_pkg::SMC_INPUTS-1:0] sample,
  input wire logic [1:0] depth,
  output logic [smc_pkg::SMC_INPUTS-1:0] filtered,
  output logic filtered_valid
);
  import smc_pkg::*;
  logic [SMC_INPUTS-1:0] last_reg;
  logic [1:0] run_reg;
  logic [1:0] run_next;
  logic accept;

  // Run counts equal repeats after the first sample; saturates at 3
  assign run_next = (sample == last_reg) ? ((run_reg == 2'h3) ? 2'h3 : run_reg + 2'h1) : 2'h0;
  assign accept = sample_take && (run_next >= depth);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= '0;
      run_reg <= 2'h0;
      filtered <= '0;
      filtered_valid <= 1'b0;
    end else begin
      filtered_valid <= accept;
      if (sample_take) begin
        last_reg <= sample;
        run_reg <= run_next;
      end
      if (accept) begin
        filtered <= sample;
      end
    end
  end

  property p_depth_zero_passes;
    @(posedge aclk) disable iff (!aresetn)
      (sample_take && depth == 2'h0) |=> (filtered_valid && filtered == $past(sample));
  endproperty
  a_depth_zero_passes: assert property (p_depth_zero_passes)
    else $error("filter depth zero dropped a sample");
endmodule

//--- smc_front_model.sv
// Front-end model: comparator samples and supply conversions
`timescale 1ns/10ps
module smc_front_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wetting_current_on,
  input wire logic supply_measure_req,
  input wire logic [23:0] pattern,
  input wire logic [9:0] supply_value,
  input wire logic [3:0] conv_delay,
  output logic [23:0] switch_sample,
  output logic sample_valid,
  output logic [9:0] supply_result,
  output logic supply_result_valid
);
  logic [1:0] gap_reg;
  logic [3:0] wait_reg;
  logic done_reg;
  logic strobe;
  assign strobe = wetting_current_on && gap_reg == 2'h3;
  // Outside a strobe the lines toggle, so stale data never looks valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= 2'h0;
      wait_reg <= 4'h0;
      done_reg <= 1'b0;
      sample_valid <= 1'b0;
      supply_result_valid <= 1'b0;
      switch_sample <= 24'h000000;
      supply_result <= 10'h000;
    end else begin
      gap_reg <= wetting_current_on ? gap_reg + 2'h1 : 2'h0;
      sample_valid <= strobe;
      switch_sample <= strobe ? pattern : ~switch_sample;
      supply_result_valid <= 1'b0;
      supply_result <= ~supply_result;
      // One conversion per request, after a settable delay
      if (!supply_measure_req) begin
        done_reg <= 1'b0;
        wait_reg <= 4'h0;
      end else if (!done_reg) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg == conv_delay) begin
          supply_result_valid <= 1'b1;
          supply_result <= supply_value;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule

//--- smc_pkg.sv
// Shared constants and types for the switch monitor register bank
package smc_pkg;
  // Register indices and byte addresses (byte address is four times the index)
  localparam logic [7:0] SMC_IDX_RESULT = 8'h16;
  localparam logic [7:0] SMC_IDX_SETUP = 8'h1A;
  localparam logic [7:0] SMC_ADDR_RESULT = 8'h58;
  localparam logic [7:0] SMC_ADDR_SETUP = 8'h68;
  localparam int SMC_ADDR_W = 8;
  localparam int SMC_REG_W = 24;
  localparam int SMC_INPUTS = 24;
  localparam int SMC_ADC_W = 10;
  // Result register fields
  localparam int SMC_SELFTEST_LSB = 10;
  localparam int SMC_SELFTEST_MSB = 19;
  localparam int SMC_SUPPLY_LSB = 0;
  localparam int SMC_SUPPLY_MSB = 9;
  localparam int SMC_RES_RSV_LSB = 20;
  // Setup register fields
  localparam int SMC_DIV_SEL_BIT = 23;
  localparam int SMC_SELFTEST_EN_BIT = 22;
  localparam int SMC_DIAG_EN_MSB = 21;
  localparam int SMC_DIAG_EN_LSB = 18;
  localparam int SMC_SUPPLY_EN_BIT = 17;
  localparam int SMC_CUTBACK_DIS_BIT = 16;
  localparam int SMC_DEPTH_MSB = 15;
  localparam int SMC_DEPTH_LSB = 14;
  localparam int SMC_RUN_BIT = 11;
  localparam int SMC_POLL_EN_BIT = 10;
  // Reset values
  localparam logic [23:0] SMC_RESULT_RST = 24'h000000;
  localparam logic [23:0] SMC_SETUP_RST = 24'h000000;
  // Divider factors selected by the divider bit
  localparam logic [3:0] SMC_DIV_LOW = 4'h3;
  localparam logic [3:0] SMC_DIV_HIGH = 4'hA;
  // AXI responses
  localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;
  // Register select codes
  typedef enum logic [1:0] {
    SMC_SEL_NONE = 2'b00,
    SMC_SEL_RESULT = 2'b01,
    SMC_SEL_SETUP = 2'b10
  } smc_sel_t;
  // Polling sequencer states
  typedef enum logic [1:0] {
    SMC_ST_IDLE = 2'b00,
    SMC_ST_SENSE = 2'b01,
    SMC_ST_MEASURE = 2'b10,
    SMC_ST_SLEEP = 2'b11
  } smc_state_t;
endpackage

//--- smc_poll_seq.sv
// Polling cycle sequencer: run/idle, continuous or polled, supply sampling
`timescale 1ns/10ps
module smc_poll_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic poll_enable,
  input wire logic supply_enable,
  input wire logic sample_valid,
  input wire logic poll_tick,
  input wire logic supply_done,
  output logic sense_take,
  output logic wetting_on,
  output logic supply_req
);
  import smc_pkg::*;
  smc_state_t state_reg;
  smc_state_t state_next;
  smc_state_t after_cycle;

  assign sense_take = (state_reg == SMC_ST_SENSE) && sample_valid && run;
  // Continuous mode starts the next cycle at once; polling waits for the tick
  assign after_cycle = poll_enable ? SMC_ST_SLEEP : SMC_ST_SENSE;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SMC_ST_IDLE: state_next = SMC_ST_SENSE;
      SMC_ST_SENSE: if (sample_valid) state_next = supply_enable ? SMC_ST_MEASURE : after_cycle;
      SMC_ST_MEASURE: if (supply_done) state_next = after_cycle;
      SMC_ST_SLEEP: if (poll_tick) state_next = SMC_ST_SENSE;
      default: state_next = SMC_ST_IDLE;
    endcase
    if (!run) state_next = SMC_ST_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SMC_ST_IDLE;
      wetting_on <= 1'b0;
      supply_req <= 1'b0;
    end else begin
      state_reg <= state_next;
      wetting_on <= (state_next == SMC_ST_SENSE);
      supply_req <= (state_next == SMC_ST_MEASURE);
    end
  end
endmodule

//--- smc_switch_monitor.sv
// Switch monitor register bank: AXI4-Lite slave, setup and result registers
`timescale 1ns/10ps
module smc_switch_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [smc_pkg::SMC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [smc_pkg::SMC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [smc_pkg::SMC_INPUTS-1:0] switch_sample,
  input wire logic sample_valid,
  input wire logic poll_tick,
  input wire logic [smc_pkg::SMC_ADC_W-1:0] selftest_result,
  input wire logic selftest_result_valid,
  input wire logic [smc_pkg::SMC_ADC_W-1:0] supply_result,
  input wire logic supply_result_valid,
  input wire logic thermal_warning,
  input wire logic [smc_pkg::SMC_INPUTS-1:0] sink_high_current,
  output logic [smc_pkg::SMC_INPUTS-1:0] switch_state,
  output logic switch_state_valid,
  output logic wetting_current_on,
  output logic supply_measure_req,
  output logic supply_divider_select,
  output logic [3:0] supply_divider_factor,
  output logic converter_selftest_enable,
  output logic [3:0] current_diag_enable,
  output logic [smc_pkg::SMC_INPUTS-1:0] sink_cutback
);
  import smc_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic smc_sel_t decode_addr(input logic [SMC_ADDR_W-1:0] addr);
    if (addr == SMC_ADDR_RESULT) decode_addr = SMC_SEL_RESULT;
    else if (addr == SMC_ADDR_SETUP) decode_addr = SMC_SEL_SETUP;
    else decode_addr = SMC_SEL_NONE;
  endfunction

  logic [SMC_REG_W-1:0] setup_reg;
  logic [SMC_REG_W-1:0] setup_next;
  logic [SMC_REG_W-1:0] result_reg;
  logic [SMC_REG_W-1:0] result_next;
  logic [SMC_ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_done_reg;
  logic w_done_reg;
  logic cutback_dis_q;

  // Setup fields
  wire run = setup_reg[SMC_RUN_BIT];
  wire poll_enable = setup_reg[SMC_POLL_EN_BIT];
  wire supply_enable = setup_reg[SMC_SUPPLY_EN_BIT];
  wire selftest_enable = setup_reg[SMC_SELFTEST_EN_BIT];
  wire cutback_disable = setup_reg[SMC_CUTBACK_DIS_BIT];
  wire [1:0] depth = setup_reg[SMC_DEPTH_MSB:SMC_DEPTH_LSB];

  // Write channel
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_done_reg || aw_take;
  wire w_have = w_done_reg || w_take;
  wire [SMC_ADDR_W-1:0] waddr = aw_done_reg ? waddr_reg : s_axi_awaddr;
  wire [31:0] wdata = w_done_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wstrb = w_done_reg ? wstrb_reg : s_axi_wstrb;
  wire commit = aw_have && w_have && !s_axi_bvalid;
  wire smc_sel_t wsel = decode_addr(waddr);
  wire setup_wr = commit && (wsel == SMC_SEL_SETUP);
  // Lanes above bit 23 have no storage, so byte lane 3 is dropped
  wire [SMC_REG_W-1:0] lane_mask = {{8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [1:0] wresp = (wsel == SMC_SEL_NONE) ? SMC_RESP_SLVERR : SMC_RESP_OKAY;

  // Read channel
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire smc_sel_t rsel = decode_addr(s_axi_araddr);
  wire [31:0] rword = (rsel == SMC_SEL_RESULT) ? {8'h00, result_reg} :
                      (rsel == SMC_SEL_SETUP) ? {8'h00, setup_reg} : 32'h00000000;
  wire [1:0] rresp = (rsel == SMC_SEL_NONE) ? SMC_RESP_SLVERR : SMC_RESP_OKAY;

  // Setup register: any write lands even while running; host must stop first
  assign setup_next = setup_wr ? ((setup_reg & ~lane_mask) | (wdata[SMC_REG_W-1:0] & lane_mask))
                               : setup_reg;

  // Result register captures converter outputs; reserved bits are never loaded
  always_comb begin
    result_next = result_reg;
    result_next[SMC_RES_RSV_LSB+3:SMC_RES_RSV_LSB] = 4'h0;
    if (selftest_result_valid && selftest_enable) begin
      result_next[SMC_SELFTEST_MSB:SMC_SELFTEST_LSB] = selftest_result;
    end
    if (supply_result_valid && supply_measure_req) begin
      result_next[SMC_SUPPLY_MSB:SMC_SUPPLY_LSB] = supply_result;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_reg <= SMC_SETUP_RST;
      result_reg <= SMC_RESULT_RST;
    end else begin
      setup_reg <= setup_next;
      result_reg <= result_next;
    end
  end

  // Write handshake: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SMC_RESP_OKAY;
      aw_done_reg <= 1'b0;
      w_done_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        waddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      aw_done_reg <= aw_have && !commit;
      w_done_reg <= w_have && !commit;
      if (commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wresp;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read handshake: one outstanding read, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= SMC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rword;
      s_axi_rresp <= rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control outputs, registered so they settle one cycle after the setup write; sink_cutback uses setup_reg, so it follows a cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_divider_select <= 1'b0;
      supply_divider_factor <= SMC_DIV_LOW;
      converter_selftest_enable <= 1'b0;
      current_diag_enable <= 4'h0;
      sink_cutback <= '0;
      cutback_dis_q <= 1'b0;
    end else begin
      supply_divider_select <= setup_next[SMC_DIV_SEL_BIT];
      supply_divider_factor <= setup_next[SMC_DIV_SEL_BIT] ? SMC_DIV_HIGH : SMC_DIV_LOW;
      converter_selftest_enable <= setup_next[SMC_SELFTEST_EN_BIT];
      current_diag_enable <= setup_next[SMC_DIAG_EN_MSB:SMC_DIAG_EN_LSB];
      cutback_dis_q <= cutback_disable;
      // Cutback only matters while current flows; idle keeps it off
      sink_cutback <= (thermal_warning && !cutback_disable && run) ?
                      sink_high_current : '0;
    end
  end

  logic sense_take;

  smc_poll_seq u_poll (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .poll_enable(poll_enable),
    .supply_enable(supply_enable),
    .sample_valid(sample_valid),
    .poll_tick(poll_tick),
    .supply_done(supply_result_valid),
    .sense_take(sense_take),
    .wetting_on(wetting_current_on),
    .supply_req(supply_measure_req)
  );

  smc_debounce u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_take(sense_take),
    .sample(switch_sample),
    .depth(depth),
    .filtered(switch_state),
    .filtered_valid(switch_state_valid)
  );

  // Checks
  sequence s_setup_write;
    setup_wr && wstrb[2];
  endsequence

  sequence s_cycle_end_with_supply;
    sense_take && supply_enable;
  endsequence

  property p_selftest_field;
    (selftest_result_valid && selftest_enable) |=>
      result_reg[SMC_SELFTEST_MSB:SMC_SELFTEST_LSB] == $past(selftest_result);
  endproperty
  a_selftest_field: assert property (p_selftest_field) else $error("selftest field not loaded");

  property p_supply_field;
    (supply_result_valid && supply_measure_req) |=>
      result_reg[SMC_SUPPLY_MSB:SMC_SUPPLY_LSB] == $past(supply_result);
  endproperty
  a_supply_field: assert property (p_supply_field) else $error("supply field not loaded");

  property p_result_read;
    (ar_take && rsel == SMC_SEL_RESULT) |=> s_axi_rvalid && s_axi_rdata == {8'h00, $past(result_reg)};
  endproperty
  a_result_read: assert property (p_result_read) else $error("result read wrong");

  property p_divider;
    s_setup_write |=> supply_divider_select == $past(wdata[SMC_DIV_SEL_BIT]) &&
      supply_divider_factor == ($past(wdata[SMC_DIV_SEL_BIT]) ? SMC_DIV_HIGH : SMC_DIV_LOW);
  endproperty
  a_divider: assert property (p_divider) else $error("divider select wrong");

  property p_selftest_gate;
    (selftest_result_valid && !selftest_enable && !supply_result_valid) |=> $stable(result_reg);
  endproperty
  a_selftest_gate: assert property (p_selftest_gate) else $error("selftest loaded while off");

  property p_diag_enables;
    s_setup_write |=> current_diag_enable == $past(wdata[SMC_DIAG_EN_MSB:SMC_DIAG_EN_LSB]);
  endproperty
  a_diag_enables: assert property (p_diag_enables) else $error("diag enables wrong");

  property p_supply_request;
    s_cycle_end_with_supply |=> supply_measure_req [*1] ##0 !wetting_current_on;
  endproperty
  a_supply_request: assert property (p_supply_request) else $error("no supply request");

  property p_cutback_off;
    (cutback_disable && cutback_dis_q) |-> sink_cutback == '0;
  endproperty
  a_cutback_off: assert property (p_cutback_off) else $error("cutback while disabled");

  property p_cutback_on;
    (thermal_warning && !cutback_disable && run) |=> sink_cutback == $past(sink_high_current);
  endproperty
  a_cutback_on: assert property (p_cutback_on) else $error("cutback missing");

  property p_setup_reset;
    $past(!aresetn) |-> setup_reg == SMC_SETUP_RST && result_reg == SMC_RESULT_RST;
  endproperty
  a_setup_reset: assert property (@(posedge aclk) p_setup_reset) else $error("reset value wrong");

  property p_idle_stop;
    !run |=> !wetting_current_on && !supply_measure_req;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("active while idle");

  property p_poll_sleep;
    (sense_take && poll_enable && !supply_enable) |=> !wetting_current_on;
  endproperty
  a_poll_sleep: assert property (p_poll_sleep) else $error("polling did not sleep");

  property p_reserved_zero;
    s_axi_rvalid |-> s_axi_rdata[31:SMC_RES_RSV_LSB+4] == 8'h00 &&
      (s_axi_rresp != SMC_RESP_OKAY || result_reg[SMC_RES_RSV_LSB+3:SMC_RES_RSV_LSB] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
endmodule

//--- smc_switch_monitor_tb.sv
// Self-checking bench for the switch monitor register bank
`timescale 1ns/10ps
module smc_switch_monitor_tb;
  import smc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0] wstrb, supply_divider_factor, current_diag_enable, conv_delay;
  logic [1:0] bresp, rresp, bresp_q, rresp_q;
  logic [23:0] switch_sample, switch_state, sink_high_current, sink_cutback, pat;
  logic sample_valid, poll_tick, selftest_result_valid, supply_result_valid;
  logic thermal_warning, switch_state_valid, wetting_current_on, supply_measure_req;
  logic supply_divider_select, converter_selftest_enable, req_seen;
  logic [9:0] selftest_result, supply_result, supply_value;
  int err_total, comparisons, cnt, n;
  smc_switch_monitor u_smc_switch_monitor (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .switch_sample(switch_sample), .sample_valid(sample_valid),
    .poll_tick(poll_tick), .selftest_result(selftest_result),
    .selftest_result_valid(selftest_result_valid), .supply_result(supply_result),
    .supply_result_valid(supply_result_valid), .thermal_warning(thermal_warning),
    .sink_high_current(sink_high_current), .switch_state(switch_state),
    .switch_state_valid(switch_state_valid), .wetting_current_on(wetting_current_on),
    .supply_measure_req(supply_measure_req), .supply_divider_select(supply_divider_select),
    .supply_divider_factor(supply_divider_factor),
    .converter_selftest_enable(converter_selftest_enable),
    .current_diag_enable(current_diag_enable), .sink_cutback(sink_cutback));
  smc_front_model u_smc_front_model (.aclk(aclk), .aresetn(aresetn),
    .wetting_current_on(wetting_current_on), .supply_measure_req(supply_measure_req),
    .pattern(pat), .supply_value(supply_value), .conv_delay(conv_delay),
    .switch_sample(switch_sample), .sample_valid(sample_valid),
    .supply_result(supply_result), .supply_result_valid(supply_result_valid));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (supply_measure_req === 1'b1) req_seen <= 1'b1;
  task automatic complete_run();
    $display("Counts: comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tmo();
    err_total++;
    $display("[ERR] t=%0t wait expired seen=%h exp=%h", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bresp_q = bresp;
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd_q = rdata;
        rresp_q = rresp;
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  // 0 wetting, 1 supply request
  task automatic wait_for(input int w, input logic lvl);
    for (int i = 0; i < 300; i++) begin
      @(posedge aclk);
      if ((w == 0 ? wetting_current_on : supply_measure_req) === lvl) return;
    end
    tmo();
  endtask
  task automatic selftest_pulse(input logic [9:0] v);
    @(posedge aclk);
    selftest_result <= v;
    selftest_result_valid <= 1'b1;
    @(posedge aclk);
    selftest_result <= ~v;
    selftest_result_valid <= 1'b0;
  endtask
  localparam logic [31:0] RUN = 32'h1 << SMC_RUN_BIT;
  localparam logic [31:0] SUP = 32'h1 << SMC_SUPPLY_EN_BIT;
  localparam logic [31:0] POLL = 32'h1 << SMC_POLL_EN_BIT;
  localparam logic [31:0] CUT = 32'h1 << SMC_CUTBACK_DIS_BIT;
  localparam logic [31:0] ST = 32'h2A5 << SMC_SELFTEST_LSB;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, poll_tick, thermal_warning} = '0;
    {selftest_result_valid, req_seen, aresetn} = '0;
    {awaddr, araddr, wdata, wstrb, selftest_result, sink_high_current} = '0;
    pat = 24'h000000;
    supply_value = 10'h000;
    conv_delay = 4'h0;
    err_total = 0;
    comparisons = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SMC_ADDR_RESULT);
    chk(rd_q, 32'h0);
    rd(SMC_ADDR_SETUP);
    chk(rd_q, 32'h0);
    chk(supply_divider_factor, SMC_DIV_LOW);
    $display("Test reset done, errors %0d", err_total);
    wr(SMC_ADDR_SETUP, 32'hFFFFF7FF, 4'hF);
    chk(bresp_q, SMC_RESP_OKAY);
    rd(SMC_ADDR_SETUP);
    chk(rd_q, 32'h00FFF7FF);
    chk(supply_divider_select, 1'b1);
    chk(supply_divider_factor, SMC_DIV_HIGH);
    chk(converter_selftest_enable, 1'b1);
    chk(current_diag_enable, 4'hF);
    wr(SMC_ADDR_SETUP, 32'h0, 4'h1);
    rd(SMC_ADDR_SETUP);
    chk(rd_q, 32'h00FFF700);
    for (int i = 0; i < 4; i++) begin
      wr(SMC_ADDR_SETUP, 32'h1 << (SMC_DIAG_EN_LSB + i), 4'hF);
      chk(current_diag_enable, 32'h1 << i);
    end
    wr(SMC_ADDR_RESULT, 32'h00ABCDEF, 4'hF);
    chk(bresp_q, SMC_RESP_OKAY);
    rd(SMC_ADDR_RESULT);
    chk(rd_q, 32'h0);
    wr(8'h40, 32'h1, 4'hF);
    chk(bresp_q, SMC_RESP_SLVERR);
    rd(8'h40);
    chk(rd_q, 32'h0);
    chk(rresp_q, SMC_RESP_SLVERR);
    $display("Test registers done, errors %0d", err_total);
    wr(SMC_ADDR_SETUP, 32'h1 << SMC_SELFTEST_EN_BIT, 4'hF);
    selftest_pulse(10'h2A5);
    rd(SMC_ADDR_RESULT);
    chk(rd_q, ST);
    wr(SMC_ADDR_SETUP, 32'h0, 4'hF);
    selftest_pulse(10'h15A);
    rd(SMC_ADDR_RESULT);
    chk(rd_q, ST);
    $display("Test selftest done, errors %0d", err_total);
    // Run is dropped before every reconfiguration
    for (int d = 0; d < 4; d++) begin
      wr(SMC_ADDR_SETUP, d << SMC_DEPTH_LSB, 4'hF);
      pat <= 24'hA50F00 ^ 24'(d + 1);
      cnt = 0;
      wr(SMC_ADDR_SETUP, (d << SMC_DEPTH_LSB) | RUN, 4'hF);
      for (n = 0; n < 400; n++) begin
        @(posedge aclk);
        if (switch_state_valid && switch_state === pat) break;
        if (sample_valid && switch_sample === pat) cnt++;
      end
      if (n >= 400) tmo();
      chk(cnt, d + 1);
      wr(SMC_ADDR_SETUP, d << SMC_DEPTH_LSB, 4'hF);
      wait_for(0, 1'b0);
    end
    chk(req_seen, 1'b0);
    $display("Test filter done, errors %0d", err_total);
    for (int k = 0; k < 2; k++) begin
      supply_value <= k ? 10'h0D2 : 10'h3C7;
      conv_delay <= k ? 4'h0 : 4'h9;
      wr(SMC_ADDR_SETUP, SUP, 4'hF);
      wr(SMC_ADDR_SETUP, SUP | RUN, 4'hF);
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      rd(SMC_ADDR_RESULT);
      chk(rd_q, ST | (k ? 32'h0D2 : 32'h3C7));
      wr(SMC_ADDR_SETUP, SUP, 4'hF);
      wait_for(0, 1'b0);
    end
    $display("Test supply done, errors %0d", err_total);
    wr(SMC_ADDR_SETUP, POLL, 4'hF);
    wr(SMC_ADDR_SETUP, POLL | RUN, 4'hF);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    repeat (20) @(posedge aclk);
    chk(wetting_current_on, 1'b0);
    poll_tick <= 1'b1;
    @(posedge aclk);
    poll_tick <= 1'b0;
    wait_for(0, 1'b1);
    wr(SMC_ADDR_SETUP, POLL, 4'hF);
    wait_for(0, 1'b0);
    $display("Test polling done, errors %0d", err_total);
    sink_high_current <= 24'h00F0F3;
    thermal_warning <= 1'b1;
    wr(SMC_ADDR_SETUP, 32'h0, 4'hF);
    wr(SMC_ADDR_SETUP, RUN, 4'hF);
    repeat (4) @(posedge aclk);
    chk(sink_cutback, 24'h00F0F3);
    wr(SMC_ADDR_SETUP, 32'h0, 4'hF);
    wr(SMC_ADDR_SETUP, CUT, 4'hF);
    wr(SMC_ADDR_SETUP, CUT | RUN, 4'hF);
    repeat (4) @(posedge aclk);
    chk(sink_cutback, 24'h000000);
    wr(SMC_ADDR_SETUP, CUT, 4'hF);
    thermal_warning <= 1'b0;
    $display("Test cutback done, errors %0d", err_total);
    // Reset with both registers loaded, so the cleared values mean something
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SMC_ADDR_SETUP);
    chk(rd_q, 32'h0);
    rd(SMC_ADDR_RESULT);
    chk(rd_q, 32'h0);
    chk(sink_cutback, 24'h000000);
    $display("Test second reset done, errors %0d", err_total);
    complete_run();
  end
endmodule
